//--- rtl/pfce_host.sv
// Host controller driving a parallel NOR flash through its pins
// Summary of operation
// - Write strobe pulses low, select low, enable high
// - Rewrite both parameters before main erased again
// - Rewrite main, parameter before boot again
// - Rewrite other parameter before one again
`timescale 1ns/1ps
module pfce_host #(
  parameter int TIMEOUT_CYC = pfce_pkg::TMO_CYC
) (
  input  wire logic                        clk,         // 50 MHz clock
  input  wire logic                        arst_n,      // Asynchronous reset
  input  wire logic                        cmd_valid,   // Command offered
  output logic                             cmd_ready,   // Command taken when idle
  input  wire logic [1:0]                  cmd_op,      // Operation code
  input  wire logic [pfce_pkg::ADDR_W:0]   cmd_addr,    // Word address, or byte address in byte mode
  input  wire logic [1:0]                  cmd_sector,  // Sector for sector erase
  input  wire logic [pfce_pkg::DATA_W-1:0] cmd_wdata,   // Program data
  input  wire logic                        cmd_hv,      // Request boot override voltage
  input  wire logic                        byte_mode,   // 1 selects byte width
  input  wire logic                        abort,       // Abort running operation
  output logic                             rsp_valid,   // One-cycle completion
  output logic [pfce_pkg::DATA_W-1:0]      rsp_rdata,   // Read data
  output logic                             rsp_error,   // Timeout or abort
  output logic                             order_warn,  // Erase order advisory
  output logic                             busy,        // Operation in progress
  output logic [pfce_pkg::ADDR_W-1:0]      fl_addr,     // Flash address pins
  output logic                             fl_ce_n,     // Chip select
  output logic                             fl_oe_n,     // Output enable
  output logic                             fl_we_n,     // Write strobe
  output logic                             fl_rst_n,    // Flash reset
  output logic                             fl_byte_n,   // Width select, low for byte
  output logic                             fl_hv_en,    // Enables 12 V on reset pin
  output logic [pfce_pkg::DATA_W-1:0]      fl_dq_o,     // Data pins out
  output logic [pfce_pkg::DATA_W-1:0]      fl_dq_oe,    // Data pins drive enable
  input  wire logic [pfce_pkg::DATA_W-1:0] fl_dq_i,     // Data pins in
  input  wire logic                        fl_ready     // Ready line level, high when idle
);
  localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYC - 1);

  pfce_pkg::pfce_state_t               state_reg, state_next;
  logic [2:0]                          step_reg, step_next;
  logic [7:0]                          wait_reg, wait_next;
  logic [31:0]                         tmo_reg, tmo_next;
  pfce_pkg::pfce_op_t                  op_reg, op_next;
  logic [pfce_pkg::ADDR_W:0]           addr_reg, addr_next;
  logic [pfce_pkg::DATA_W-1:0]         wdata_reg, wdata_next;
  logic [1:0]                          sect_reg, sect_next;
  logic                                hv_reg, hv_next;
  logic                                prev_reg, prev_next;
  logic                                first_reg, first_next;
  logic [pfce_pkg::ADDR_W-1:0]         ao_reg, ao_next;
  logic [pfce_pkg::DATA_W-1:0]         dq_reg, dq_next;
  logic [pfce_pkg::DATA_W-1:0]         rdata_reg, rdata_next;
  logic                                rv_reg, rv_next;
  logic                                err_reg, err_next;
  logic                                warn_reg, warn_next;
  logic [pfce_pkg::NSECT-1:0]          pend_reg [pfce_pkg::NSECT];
  logic [pfce_pkg::NSECT-1:0]          pend_next [pfce_pkg::NSECT];
  logic                                wr_act, ce_act, erase_go, chip_go;
  logic [pfce_pkg::ADDR_W+pfce_pkg::DATA_W-1:0] word_nx;
  logic [2:0]                          last_step;

  // Address and data of one command cycle
  function automatic logic [pfce_pkg::ADDR_W+pfce_pkg::DATA_W-1:0] cmd_word(
    input pfce_pkg::pfce_op_t op, input logic [2:0] step, input logic [pfce_pkg::ADDR_W:0] addr,
    input logic [1:0] sect, input logic [pfce_pkg::DATA_W-1:0] wd, input logic bm);
    logic [pfce_pkg::ADDR_W-1:0] a;
    logic [7:0]                  c;
    logic                        lsb;
    a   = pfce_pkg::UNL_ADDR1;
    c   = pfce_pkg::CODE_AA;
    lsb = 1'b0;
    case (step)
      3'h1, 3'h4: begin a = pfce_pkg::UNL_ADDR2; c = pfce_pkg::CODE_55; end
      3'h2:       c = (op == pfce_pkg::PFCE_OP_PROG) ? pfce_pkg::CODE_A0 : pfce_pkg::CODE_80;
      3'h5:       if (op == pfce_pkg::PFCE_OP_CHIP)
                    c = pfce_pkg::CODE_CHIP;
                  else
                  begin
                    a = pfce_pkg::SECT_BASE[sect];
                    c = pfce_pkg::CODE_SECT;
                  end
      default:    ;
    endcase
    if (op == pfce_pkg::PFCE_OP_PROG && step == pfce_pkg::PROG_LAST)
    begin
      a   = bm ? addr[pfce_pkg::ADDR_W:1] : addr[pfce_pkg::ADDR_W-1:0];
      lsb = bm & addr[0];
      // Program data only clears bits; nothing erases the word before it is programmed
      return {a, bm ? {lsb, 7'h00, wd[7:0]} : wd};
    end
    return {a, bm ? {lsb, 7'h00, c} : {8'h00, c}};
  endfunction

  assign last_step = (op_reg == pfce_pkg::PFCE_OP_PROG) ? pfce_pkg::PROG_LAST : pfce_pkg::ERASE_LAST;
  assign word_nx   = cmd_word(op_reg, step_reg + 3'h1, addr_reg, sect_reg, wdata_reg, byte_mode);
  assign wr_act    = state_reg inside {pfce_pkg::PFCE_WA, pfce_pkg::PFCE_WL, pfce_pkg::PFCE_WH};
  assign ce_act    = wr_act | (state_reg inside {pfce_pkg::PFCE_RD, pfce_pkg::PFCE_PR});
  assign erase_go  = state_reg == pfce_pkg::PFCE_WG && step_reg == last_step && op_reg != pfce_pkg::PFCE_OP_PROG;
  assign chip_go   = erase_go && op_reg == pfce_pkg::PFCE_OP_CHIP;

  // Pin controls decode the one-hot state; no select is active in idle or reset
  assign fl_ce_n   = !ce_act;
  assign fl_oe_n   = !(state_reg inside {pfce_pkg::PFCE_RD, pfce_pkg::PFCE_PR});
  assign fl_we_n   = state_reg != pfce_pkg::PFCE_WL;
  assign fl_rst_n  = state_reg != pfce_pkg::PFCE_RST;
  assign fl_byte_n = !byte_mode;
  // Line 15 carries the low address bit in byte mode, even during reads
  assign fl_dq_oe  = byte_mode ? {ce_act, 7'h00, {8{wr_act}}} : {16{wr_act}};
  assign fl_hv_en  = hv_reg && !(state_reg inside {pfce_pkg::PFCE_IDLE, pfce_pkg::PFCE_RD,
                                                    pfce_pkg::PFCE_RST});
  assign fl_addr    = ao_reg;
  assign fl_dq_o    = dq_reg;
  assign cmd_ready  = state_reg == pfce_pkg::PFCE_IDLE;
  assign busy       = !cmd_ready;
  assign rsp_valid  = rv_reg;
  assign rsp_rdata  = rdata_reg;
  assign rsp_error  = err_reg;
  assign order_warn = warn_reg;

  always_comb
  begin
    state_next = state_reg;
    step_next  = step_reg;
    wait_next  = wait_reg;
    tmo_next   = tmo_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    sect_next  = sect_reg;
    hv_next    = hv_reg;
    prev_next  = prev_reg;
    first_next = first_reg;
    ao_next    = ao_reg;
    dq_next    = dq_reg;
    rdata_next = rdata_reg;
    rv_next    = 1'b0;
    err_next   = 1'b0;
    if (wait_reg != 8'h00)
      wait_next = wait_reg - 8'h01;
    case (state_reg)
      pfce_pkg::PFCE_IDLE:
        if (cmd_valid)
        begin
          op_next    = pfce_pkg::pfce_op_t'(cmd_op);
          addr_next  = cmd_addr;
          wdata_next = cmd_wdata;
          sect_next  = cmd_sector;
          step_next  = 3'h0;
          tmo_next   = 32'h0;
          first_next = 1'b1;
          if (pfce_pkg::pfce_op_t'(cmd_op) == pfce_pkg::PFCE_OP_READ)
          begin
            hv_next    = 1'b0;
            ao_next    = byte_mode ? cmd_addr[pfce_pkg::ADDR_W:1] : cmd_addr[pfce_pkg::ADDR_W-1:0];
            dq_next    = {byte_mode & cmd_addr[0], 15'h0000};
            wait_next  = 8'(pfce_pkg::RD_CYC);
            state_next = pfce_pkg::PFCE_RD;
          end
          else
          begin
            hv_next = cmd_hv;
            {ao_next, dq_next} = cmd_word(pfce_pkg::pfce_op_t'(cmd_op), 3'h0, cmd_addr, cmd_sector,
                                          cmd_wdata, byte_mode);
            state_next = pfce_pkg::PFCE_WA;
          end
        end
      pfce_pkg::PFCE_RD:
        if (wait_reg == 8'h01)
        begin
          rdata_next = byte_mode ? {8'h00, fl_dq_i[7:0]} : fl_dq_i;
          rv_next    = 1'b1;
          state_next = pfce_pkg::PFCE_IDLE;
        end
      pfce_pkg::PFCE_WA:
      begin
        wait_next  = 8'(pfce_pkg::WP_CYC);
        state_next = pfce_pkg::PFCE_WL;
      end
      pfce_pkg::PFCE_WL:
        if (wait_reg == 8'h01)
          state_next = pfce_pkg::PFCE_WH;
      pfce_pkg::PFCE_WH:
        state_next = pfce_pkg::PFCE_WG;
      pfce_pkg::PFCE_WG:
        if (step_reg == last_step)
        begin
          // Device starts its internal cycle after this last strobe rise
          wait_next  = 8'(pfce_pkg::RD_CYC);
          ao_next    = (op_reg == pfce_pkg::PFCE_OP_SECT) ? pfce_pkg::SECT_BASE[sect_reg] : ao_reg;
          state_next = pfce_pkg::PFCE_PR;
        end
        else
        begin
          step_next          = step_reg + 3'h1;
          {ao_next, dq_next} = word_nx;
          state_next         = pfce_pkg::PFCE_WA;
        end
      pfce_pkg::PFCE_PR:
      begin
        tmo_next = tmo_reg + 32'h1;
        if (wait_reg == 8'h01)
        begin
          prev_next  = fl_dq_i[pfce_pkg::DQ_TOG];
          first_next = 1'b0;
          state_next = pfce_pkg::PFCE_PG;
          // Done once bit 6 stops toggling and the ready line is released
          if (!first_reg && prev_reg == fl_dq_i[pfce_pkg::DQ_TOG] && fl_ready)
          begin
            rv_next    = 1'b1;
            state_next = pfce_pkg::PFCE_IDLE;
          end
        end
      end
      pfce_pkg::PFCE_PG:
      begin
        tmo_next   = tmo_reg + 32'h1;
        wait_next  = 8'(pfce_pkg::RD_CYC);
        state_next = pfce_pkg::PFCE_PR;
      end
      pfce_pkg::PFCE_RST:
        if (wait_reg == 8'h01)
        begin
          rv_next    = 1'b1;
          err_next   = 1'b1;
          state_next = pfce_pkg::PFCE_IDLE;
        end
      default:
        state_next = pfce_pkg::PFCE_IDLE;
    endcase
    // A hung operation or an abort is ended by pulsing the flash reset
    if ((abort || tmo_reg == TMO_LAST) && busy && state_reg != pfce_pkg::PFCE_RST)
    begin
      wait_next  = 8'(pfce_pkg::RST_CYC);
      hv_next    = 1'b0;
      state_next = pfce_pkg::PFCE_RST;
    end
  end

  // Advisory erase-order tracking; the erase still runs when out of order
  assign warn_next = erase_go && !chip_go && pend_reg[sect_reg] != '0;
  generate
    for (genvar s = 0; s < pfce_pkg::NSECT; s++)
    begin : g_pend
      always_comb
      begin
        pend_next[s] = pend_reg[s];
        if (chip_go)
          pend_next[s] = '0;
        else if (erase_go && sect_reg == 2'(s))
          pend_next[s] = pfce_pkg::COMP_MASK[s];
        else if (erase_go)
          pend_next[s] = pend_reg[s] & ~(4'h1 << sect_reg);
      end
      always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
          pend_reg[s] <= '0;
        else
          pend_reg[s] <= pend_next[s];
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      state_reg <= pfce_pkg::PFCE_IDLE;
      step_reg  <= 3'h0;
      wait_reg  <= 8'h00;
      tmo_reg   <= 32'h0;
      op_reg    <= pfce_pkg::PFCE_OP_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
      sect_reg  <= 2'h0;
      hv_reg    <= 1'b0;
      prev_reg  <= 1'b0;
      first_reg <= 1'b1;
      ao_reg    <= '0;
      dq_reg    <= '0;
      rdata_reg <= '0;
      rv_reg    <= 1'b0;
      err_reg   <= 1'b0;
      warn_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      step_reg  <= step_next;
      wait_reg  <= wait_next;
      tmo_reg   <= tmo_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      sect_reg  <= sect_next;
      hv_reg    <= hv_next;
      prev_reg  <= prev_next;
      first_reg <= first_next;
      ao_reg    <= ao_next;
      dq_reg    <= dq_next;
      rdata_reg <= rdata_next;
      rv_reg    <= rv_next;
      err_reg   <= err_next;
      warn_reg  <= warn_next;
    end

  a_no_contention: assert property (@(posedge clk) disable iff (!arst_n)
    !fl_oe_n |-> fl_dq_oe[14:0] == 15'h0000) else $error("data driven while flash outputs on");
  a_write_strobe: assert property (@(posedge clk) disable iff (!arst_n)
    !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe[7:0] == 8'hff) else $error("bad write strobe levels");
  a_addr_setup: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(fl_we_n) |-> $past(!fl_ce_n) && $stable(fl_addr) ##1 $stable(fl_addr))
    else $error("address moved around strobe fall");
  a_data_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(fl_we_n) |-> $stable(fl_dq_o) && fl_dq_oe[7:0] == 8'hff && !fl_ce_n)
    else $error("data not held at strobe rise");
  a_code_upper: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(fl_we_n) && op_reg != pfce_pkg::PFCE_OP_PROG |-> fl_dq_o[14:8] == 7'h00)
    else $error("command upper byte not zero");
  a_reset_hold: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(fl_rst_n) |-> (!fl_rst_n && fl_ce_n && !fl_hv_en)[*8]) else $error("flash reset too short");
  a_reset_end: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(fl_rst_n) |-> rsp_valid && rsp_error && cmd_ready) else $error("reset not answered");
  a_byte_idle: assert property (@(posedge clk) disable iff (!arst_n)
    byte_mode |-> fl_dq_oe[14:8] == 7'h00) else $error("byte mode drives lines 8 to 14");
  a_poll_done: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == pfce_pkg::PFCE_PR && state_next == pfce_pkg::PFCE_IDLE |-> fl_ready && !first_reg)
    else $error("completion without stable toggle");
endmodule

//--- rtl/pfce_pkg.sv
// Constants and types for the parallel flash command and erase host
package pfce_pkg;
  localparam int ADDR_W     = 19;
  localparam int DATA_W     = 16;
  localparam int CLK_NS     = 20;
  localparam int T_ACC_NS   = 70;
  localparam int T_WP_NS    = 50;
  localparam int T_RST_NS   = 500;
  localparam int T_ERASE_MS = 10000;
  // Least times round up to whole clock cycles
  localparam int RD_CYC     = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC    = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMO_CYC    = T_ERASE_MS * (1000000 / CLK_NS);

  localparam logic [ADDR_W-1:0] UNL_ADDR1 = 19'h05555;
  localparam logic [ADDR_W-1:0] UNL_ADDR2 = 19'h02aaa;
  localparam logic [7:0]        CODE_AA   = 8'haa;
  localparam logic [7:0]        CODE_55   = 8'h55;
  localparam logic [7:0]        CODE_80   = 8'h80;
  localparam logic [7:0]        CODE_A0   = 8'ha0;
  localparam logic [7:0]        CODE_CHIP = 8'h10;
  localparam logic [7:0]        CODE_SECT = 8'h30;
  localparam logic [2:0]        ERASE_LAST = 3'h5;
  localparam logic [2:0]        PROG_LAST  = 3'h3;
  localparam int                DQ_TOG     = 6;
  localparam int                DQ_A_M1    = 15;
  localparam int                NSECT      = 4;

  // Sector index: 0 boot, 1 parameter 0, 2 parameter 1, 3 main
  localparam logic [ADDR_W-1:0] SECT_BASE [NSECT] = '{19'h00000, 19'h02000, 19'h03000, 19'h04000};
  // Companions that must be erased before a sector is erased again
  localparam logic [NSECT-1:0]  COMP_MASK [NSECT] = '{4'ha, 4'h4, 4'h2, 4'h6};

  typedef enum logic [1:0] {
    PFCE_OP_READ = 2'h0,
    PFCE_OP_PROG = 2'h1,
    PFCE_OP_CHIP = 2'h2,
    PFCE_OP_SECT = 2'h3
  } pfce_op_t;

  typedef enum logic [8:0] {
    PFCE_IDLE = 9'h001,
    PFCE_RD   = 9'h002,
    PFCE_WA   = 9'h004,
    PFCE_WL   = 9'h008,
    PFCE_WH   = 9'h010,
    PFCE_WG   = 9'h020,
    PFCE_PR   = 9'h040,
    PFCE_PG   = 9'h080,
    PFCE_RST  = 9'h100
  } pfce_state_t;
endpackage

//--- verif/pfce_flash_model.sv
// Behavioural model of the parallel NOR flash as seen from its pins
`timescale 1ns/1ps
module pfce_flash_model #(
  parameter int ERASE_NS = 1000,
  parameter int PROG_NS  = 200
) (
  input  wire logic [18:0] a,      // Address pins
  input  wire logic        ce_n,   // Chip select
  input  wire logic        oe_n,   // Output enable
  input  wire logic        we_n,   // Write strobe
  input  wire logic        rst_n,  // Reset pin
  input  wire logic        hv,     // Override voltage on reset pin
  input  wire logic        byte_n, // Width select, low for byte
  input  wire logic        locked, // Boot lockout enabled
  input  wire logic [15:0] dq_in,  // Resolved data lines
  output logic      [15:0] dq_out, // Read value, drifting value when released
  output logic      [15:0] dq_en,  // Per-bit drive enable
  output logic             rdy     // Ready line after its pull-up
);
  logic [15:0] mem [0:524287];
  logic [18:0] lat_a;
  logic [18:0] paddr;
  logic [15:0] pdata, rdv, last;
  logic [3:0]  emask;
  logic [2:0]  step;
  logic        prog_arm, busy, erasing, tog, w2;
  realtime     end_t;
  wire rd   = !ce_n && !oe_n && we_n && rst_n;
  wire wr   = !ce_n && !we_n && oe_n && rst_n;
  wire prot = locked && !hv;
  function automatic logic [1:0] sect_of(input logic [18:0] w);
    return (w < 19'h02000) ? 2'h0 : (w < 19'h03000) ? 2'h1 : (w < 19'h04000) ? 2'h2 : 2'h3;
  endfunction
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
    {step, prog_arm, busy, erasing, tog, last, emask} = '0;
  end
  always @*
  begin
    if (busy) rdv = {8'h00, erasing ? 1'b0 : ~pdata[7], tog, 6'h00};
    else if (!byte_n) rdv = {8'h00, dq_in[15] ? mem[a][15:8] : mem[a][7:0]};
    else rdv = mem[a];
    if (rd) last = rdv;
  end
  // Released lines show the inverse of the last value so a stale read cannot pass
  assign dq_en  = rd ? (byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
  assign dq_out = (dq_en & rdv) | (~dq_en & ~last);
  assign rdy    = !busy;
  always @(posedge rd) if (busy) tog = ~tog;
  always @(posedge wr) lat_a = a;
  always @(negedge wr) if (rst_n && oe_n && !busy) take(dq_in);
  task automatic start(input logic e, input int ns);
    busy = 1'b1;
    erasing = e;
    end_t = $realtime + ns;
  endtask
  task automatic take(input logic [15:0] d);
    w2 = (step == 3'h1 || step == 3'h4);
    if (prog_arm)
    begin
      prog_arm = 1'b0;
      paddr = lat_a;
      pdata = byte_n ? d : (d[15] ? {d[7:0], 8'hff} : {8'hff, d[7:0]});
      if (!(prot && sect_of(lat_a) == 2'h0)) start(1'b0, PROG_NS);
    end
    else if (step == 3'h5)
    begin
      step = 3'h0;
      if (d[7:0] == 8'h10 && lat_a[14:0] == 15'h5555) emask = {3'h7, !prot};
      else if (d[7:0] == 8'h30) emask = (4'h1 << sect_of(lat_a)) & {3'h7, !prot};
      else emask = 4'h0;
      if (emask != 4'h0) start(1'b1, ERASE_NS);
    end
    else if (step == 3'h2 && d[7:0] == 8'ha0 && lat_a[14:0] == 15'h5555)
    begin
      step = 3'h0;
      prog_arm = 1'b1;
    end
    else if (lat_a[14:0] == (w2 ? 15'h2aaa : 15'h5555) && d[7:0] == (step == 3'h2 ? 8'h80 : w2 ? 8'h55 : 8'haa))
      step = step + 3'h1;
    else step = 3'h0;
  endtask
  initial forever
  begin
    #10;
    if (busy && $realtime >= end_t)
    begin
      if (erasing) for (int i = 0; i < 524288; i++) if (emask[sect_of(19'(i))]) mem[i] = 16'hffff;
      if (!erasing) mem[paddr] = mem[paddr] & pdata;
      busy = 1'b0;
    end
  end
  always @(negedge rst_n)
  begin
    busy = 1'b0;
    step = 3'h0;
    prog_arm = 1'b0;
  end
endmodule

//--- verif/pfce_host_tb_top.sv
// Self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
module pfce_host_tb_top;
  logic        clk, arst_n, cmd_valid, cmd_hv, byte_mode, abort, locked, err, warn;
  logic [1:0]  cmd_op, cmd_sector;
  logic [19:0] cmd_addr;
  logic [15:0] cmd_wdata, rdata;
  wire         cmd_ready, rsp_valid, rsp_error, order_warn, busy, fl_ready;
  wire         fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, fl_byte_n, fl_hv_en;
  wire  [15:0] rsp_rdata, fl_dq_o, fl_dq_oe, m_dq, m_en, bus;
  wire  [18:0] fl_addr;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  assign bus = (fl_dq_oe & fl_dq_o) | (~fl_dq_oe & m_dq);
  pfce_host #(.TIMEOUT_CYC(200)) dut_u (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_sector(cmd_sector), .cmd_wdata(cmd_wdata), .cmd_hv(cmd_hv),
    .byte_mode(byte_mode), .abort(abort), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .order_warn(order_warn), .busy(busy), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_rst_n(fl_rst_n), .fl_byte_n(fl_byte_n), .fl_hv_en(fl_hv_en), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_dq_i(bus), .fl_ready(fl_ready));
  pfce_flash_model flash_u (.a(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .rst_n(fl_rst_n),
    .hv(fl_hv_en), .byte_n(fl_byte_n), .locked(locked), .dq_in(bus), .dq_out(m_dq), .dq_en(m_en), .rdy(fl_ready));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run needs little more than a thousand cycles; this ceiling only catches a hang
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      end_sim;
    end
  end
  always @(negedge clk) if (order_warn === 1'b1) warn = 1'b1;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic [1:0] op, input logic [19:0] ad, input logic [1:0] s, input logic [15:0] d,
                     input logic hv);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_sector <= s;
    cmd_wdata <= d;
    cmd_hv <= hv;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    warn = 1'b0;
    do @(negedge clk); while (rsp_valid !== 1'b1);
    rdata = rsp_rdata;
    err = rsp_error;
  endtask
  task automatic rd(input logic [19:0] ad, input logic [15:0] exp, input string nm);
    run(2'h0, ad, 2'h0, 16'h0000, 1'b0);
    chk(nm, rdata, exp);
  endtask
  task automatic t_reset;
    chk("idle pins", {11'h000, fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n, cmd_ready}, 16'h001f);
    chk("idle busy hv width", {13'h0000, busy, fl_hv_en, fl_byte_n}, 16'h0001);
    chk("idle drive", fl_dq_oe, 16'h0000);
  endtask
  task automatic t_prog;
    rd(20'h04100, 16'hffff, "erased word");
    run(2'h1, 20'h04100, 2'h0, 16'ha5c3, 1'b0);
    rd(20'h04100, 16'ha5c3, "programmed word");
    run(2'h1, 20'h04100, 2'h0, 16'h0ff0, 1'b0);
    rd(20'h04100, 16'h05c0, "bits only cleared");
    run(2'h1, 20'h02010, 2'h0, 16'h1111, 1'b0);
  endtask
  task automatic t_byte;
    @(posedge clk);
    byte_mode <= 1'b1;
    rd({19'h04100, 1'b1}, 16'h0005, "upper byte");
    rd({19'h04100, 1'b0}, 16'h00c0, "lower byte");
    chk("byte select pin", {15'h0000, fl_byte_n}, 16'h0000);
    @(posedge clk);
    byte_mode <= 1'b0;
  endtask
  task automatic t_sector;
    run(2'h3, 20'h00000, 2'h3, 16'h0000, 1'b0);
    chk("sector erase error", {15'h0000, err}, 16'h0000);
    rd(20'h04100, 16'hffff, "main erased");
    rd(20'h02010, 16'h1111, "parameter kept");
  endtask
  task automatic t_lock;
    locked = 1'b1;
    run(2'h1, 20'h00010, 2'h0, 16'h1234, 1'b0);
    rd(20'h00010, 16'hffff, "locked boot refused");
    run(2'h1, 20'h00010, 2'h0, 16'h1234, 1'b1);
    rd(20'h00010, 16'h1234, "override programs boot");
    run(2'h2, 20'h00000, 2'h0, 16'h0000, 1'b0);
    rd(20'h00010, 16'h1234, "chip erase spares boot");
    rd(20'h02010, 16'hffff, "chip erase clears parameter");
    locked = 1'b0;
  endtask
  task automatic t_order;
    logic [1:0] s;
    for (int i = 0; i < 6; i++)
    begin
      s = (i < 2) ? 2'h0 : (i < 4) ? 2'h1 : 2'h3;
      run(2'h3, 20'h00000, s, 16'h0000, 1'b0);
      chk("repeat erase advisory", {15'h0000, warn}, {15'h0000, i[0]});
    end
    rd(20'h00010, 16'hffff, "boot erased");
  endtask
  task automatic t_abort;
    run(2'h1, 20'h04200, 2'h0, 16'h00ff, 1'b0);
    fork
      run(2'h3, 20'h00000, 2'h3, 16'h0000, 1'b0);
      begin
        wait (fl_ready === 1'b0);
        repeat (5) @(posedge clk);
        abort <= 1'b1;
      end
    join
    chk("abort error", {15'h0000, err}, 16'h0001);
    @(posedge clk);
    abort <= 1'b0;
    rd(20'h04200, 16'h00ff, "aborted erase left data");
    chk("read after abort error", {14'h0000, err, fl_rst_n}, 16'h0001);
  endtask
  initial
  begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 20'h00000;
    cmd_sector = 2'h0;
    cmd_wdata = 16'h0000;
    cmd_hv = 1'b0;
    byte_mode = 1'b0;
    abort = 1'b0;
    locked = 1'b0;
    warn = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_prog;
    t_byte;
    t_sector;
    t_lock;
    t_order;
    t_abort;
    end_sim;
  end
endmodule
